// File: ssf_pkg.sv
// Package with command codes, field layouts, timing and carrier types.
package ssf_pkg;
  // Command codes of the two registers.
  localparam logic [7:0] SSF_CMD_FALL = 8'h65;
  localparam logic [7:0] SSF_CMD_SBYTE = 8'h78;
  // Fall-time register layout.
  localparam int SSF_EXP_LSB = 11;
  localparam int SSF_MANT_W = 4;
  localparam logic [4:0] SSF_FALL_EXP = 5'h1f;
  localparam logic [6:0] SSF_FALL_RSV = 7'h00;
  localparam logic [11:0] SSF_FALL_FIXED = 12'hf80;
  localparam logic [3:0] SSF_MANT_RST = 4'h0;
  // Range limits of the applied fall-time decode.
  localparam logic [3:0] SSF_LIM_1MS = 4'h2;
  localparam logic [3:0] SSF_LIM_2MS = 4'h4;
  localparam logic [3:0] SSF_LIM_4MS = 4'h8;
  // Mantissa restored from nonvolatile memory for each supported setting.
  localparam logic [3:0] SSF_NVM_0P5 = 4'h0;
  localparam logic [3:0] SSF_NVM_1 = 4'h2;
  localparam logic [3:0] SSF_NVM_2 = 4'h4;
  localparam logic [3:0] SSF_NVM_4 = 4'h8;
  // Fault summary byte layout and reset value.
  localparam int SSF_SB_NA7 = 7;
  localparam int SSF_SB_OFF = 6;
  localparam int SSF_SB_OVOLT = 5;
  localparam int SSF_SB_OCUR = 4;
  localparam int SSF_SB_NA3 = 3;
  localparam int SSF_SB_TEMP = 2;
  localparam int SSF_SB_CML = 1;
  localparam int SSF_SB_OTHER = 0;
  localparam logic [7:0] SSF_SB_RST = 8'h40;
  // Timing: shortest fall time and clock rate.
  localparam int SSF_FALL_MIN_US = 500;
  localparam int SSF_CLK_MHZ = 50;
  localparam int SSF_FALL_MIN_CYC = SSF_FALL_MIN_US * SSF_CLK_MHZ;
  // Boot levels and reference codes per level.
  localparam int SSF_BOOT_LVLS = 32;
  localparam int SSF_CODES_PER_LVL = 16;
  localparam int SSF_REF_W = 10;
  localparam int SSF_TICK_W = 16;
  // Soft-stop ramp states.
  typedef enum logic [1:0] {SSF_IDLE, SSF_RAMP} ssf_ramp_t;
  // Request carried from the command side to the core.
  typedef struct packed {
    logic [7:0] code;
    logic wr;
    logic [15:0] wdata;
  } ssf_req_t;
  // Answer carried back to the command side.
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } ssf_rsp_t;
  // Detailed status sources feeding the summary byte.
  typedef struct packed {
    logic converting;
    logic output_overvoltage_fault;
    logic output_overcurrent_fault;
    logic overcurrent_undervoltage;
    logic temperature_fault_warning;
    logic cml_fault;
    logic other_fault;
  } ssf_src_t;
endpackage

// File: ssf_regs.sv
// Soft-stop fall-time register, soft-stop ramp and fault summary byte.
`timescale 1ns/1ns
module ssf_regs #(
  parameter int FALL_MIN_CYC = ssf_pkg::SSF_FALL_MIN_CYC
) (
  // Core clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Command link clock and reset.
  input wire logic lk_clk_i,
  input wire logic lk_rst_i,
  // Command port on the link clock.
  input wire logic lk_req_valid_i,
  input wire ssf_pkg::ssf_req_t lk_req_i,
  output logic lk_req_ready_o,
  output logic lk_rsp_valid_o,
  output ssf_pkg::ssf_rsp_t lk_rsp_o,
  // Nonvolatile restore.
  input wire logic nvm_load_i,
  input wire logic [1:0] nvm_sel_i,
  // Soft-stop control.
  input wire logic toff_done_i,
  input wire logic soft_start_i,
  input wire logic [4:0] boot_voltage_level_i,
  input wire logic vout_cutoff_i,
  output logic [ssf_pkg::SSF_REF_W-1:0] ref_code_o,
  output logic ramp_active_o,
  output logic sw_stop_o,
  output logic [1:0] fall_sel_o,
  // Status sources and summary.
  input wire ssf_pkg::ssf_src_t src_i,
  input wire logic secondary_i,
  output logic [7:0] summary_byte_o,
  output logic ivd_set_o
);
  import ssf_pkg::*;

  localparam int TBL_W = SSF_TICK_W * SSF_BOOT_LVLS;

  // Per-level tick interval for the shortest fall time.
  function automatic logic [TBL_W-1:0] mk_tbl();
    logic [TBL_W-1:0] t;
    t = '0;
    for (int l = 0; l < SSF_BOOT_LVLS; l++) begin
      t[l*SSF_TICK_W +: SSF_TICK_W] =
        SSF_TICK_W'(FALL_MIN_CYC / ((l + 1) * SSF_CODES_PER_LVL));
    end
    return t;
  endfunction

  localparam logic [TBL_W-1:0] BASE_TBL = mk_tbl();

  // Link-domain state.
  typedef struct packed {
    logic pend;
    logic req_tgl;
    ssf_req_t req;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic rsp_valid;
    ssf_rsp_t rsp;
  } ssf_lk_t;

  // Core-domain state.
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic rsp_tgl;
    ssf_rsp_t rsp;
    logic [SSF_MANT_W-1:0] mant;
    ssf_ramp_t st;
    logic [SSF_REF_W-1:0] ref_code;
    logic [SSF_TICK_W-1:0] cnt;
    logic stop;
    logic cut_s1;
    logic cut_s2;
    logic [7:0] sb;
    logic ivd;
  } ssf_core_t;

  ssf_lk_t lk_q, lk_d;
  ssf_core_t cr_q, cr_d;
  ssf_core_t cr_rst;
  ssf_lk_t lk_rst;
  logic [1:0] fall_sel;
  logic [SSF_TICK_W-1:0] tick_cyc;
  logic req_new;
  logic fall_wr_ok;
  logic [7:0] sb_next;

  always_comb begin
    lk_rst = '0;
    cr_rst = '0;
    cr_rst.mant = SSF_MANT_RST;
    cr_rst.st = SSF_IDLE;
    cr_rst.sb = SSF_SB_RST;
  end

  // Command side: hold a request until its answer comes back.
  always_comb begin
    lk_d = lk_q;
    lk_d.rsp_valid = 1'b0;
    lk_d.ack_s1 = cr_q.rsp_tgl;
    lk_d.ack_s2 = lk_q.ack_s1;
    if (!lk_q.pend && lk_req_valid_i) begin
      lk_d.pend = 1'b1;
      lk_d.req = lk_req_i;
      lk_d.req_tgl = ~lk_q.req_tgl;
    end
    if (lk_q.pend && (lk_q.ack_s2 != lk_q.ack_seen)) begin
      lk_d.ack_seen = lk_q.ack_s2;
      lk_d.pend = 1'b0;
      lk_d.rsp_valid = 1'b1;
      lk_d.rsp = cr_q.rsp;
    end
  end

  always_ff @(posedge lk_clk_i) begin
    if (lk_rst_i) begin
      lk_q <= lk_rst;
    end else begin
      lk_q <= lk_d;
    end
  end

  assign lk_req_ready_o = !lk_q.pend;
  assign lk_rsp_valid_o = lk_q.rsp_valid;
  assign lk_rsp_o = lk_q.rsp;

  // Applied fall time from the mantissa range.
  always_comb begin
    if (cr_q.mant < SSF_LIM_1MS) begin
      fall_sel = 2'd0;
    end else if (cr_q.mant < SSF_LIM_2MS) begin
      fall_sel = 2'd1;
    end else if (cr_q.mant < SSF_LIM_4MS) begin
      fall_sel = 2'd2;
    end else begin
      fall_sel = 2'd3;
    end
  end

  // Soft-stop slew per boot level, scaled by the fall setting.
  assign tick_cyc = BASE_TBL[boot_voltage_level_i*SSF_TICK_W +: SSF_TICK_W]
    << fall_sel;

  assign req_new = cr_q.req_s2 != cr_q.req_seen;
  assign fall_wr_ok = lk_q.req.wdata[15:SSF_MANT_W] == SSF_FALL_FIXED;

  // Summary byte built from the detailed sources.
  always_comb begin
    sb_next = '0;
    sb_next[SSF_SB_NA7] = 1'b0;
    sb_next[SSF_SB_NA3] = 1'b0;
    sb_next[SSF_SB_OFF] = !src_i.converting;
    sb_next[SSF_SB_OVOLT] = src_i.output_overvoltage_fault;
    sb_next[SSF_SB_OCUR] = src_i.output_overcurrent_fault |
      src_i.overcurrent_undervoltage;
    sb_next[SSF_SB_TEMP] = src_i.temperature_fault_warning;
    sb_next[SSF_SB_CML] = src_i.cml_fault;
    sb_next[SSF_SB_OTHER] = src_i.other_fault;
    if (secondary_i) begin
      sb_next = '0;
    end
  end

  always_comb begin
    cr_d = cr_q;
    cr_d.req_s1 = lk_q.req_tgl;
    cr_d.req_s2 = cr_q.req_s1;
    cr_d.cut_s1 = vout_cutoff_i;
    cr_d.cut_s2 = cr_q.cut_s1;
    cr_d.ivd = 1'b0;
    cr_d.sb = sb_next;
    if (nvm_load_i) begin
      unique case (nvm_sel_i)
        2'd0: cr_d.mant = SSF_NVM_0P5;
        2'd1: cr_d.mant = SSF_NVM_1;
        2'd2: cr_d.mant = SSF_NVM_2;
        2'd3: cr_d.mant = SSF_NVM_4;
      endcase
    end
    // Command handling; the answer toggles back once per request.
    if (req_new) begin
      cr_d.req_seen = cr_q.req_s2;
      cr_d.rsp_tgl = ~cr_q.rsp_tgl;
      cr_d.rsp = '0;
      if (lk_q.req.code == SSF_CMD_FALL) begin
        if (!lk_q.req.wr) begin
          cr_d.rsp.ack = 1'b1;
          cr_d.rsp.rdata = {SSF_FALL_EXP, SSF_FALL_RSV,
            cr_q.mant};
        end else if (fall_wr_ok) begin
          cr_d.rsp.ack = 1'b1;
          cr_d.mant = lk_q.req.wdata[SSF_MANT_W-1:0];
        end else begin
          cr_d.ivd = 1'b1;
        end
      end else if (lk_q.req.code == SSF_CMD_SBYTE) begin
        if (!lk_q.req.wr) begin
          cr_d.rsp.ack = 1'b1;
          cr_d.rsp.rdata = {8'h00, cr_q.sb};
        end else begin
          cr_d.ivd = 1'b1;
        end
      end
    end
    // Soft-stop reference ramp.
    unique case (cr_q.st)
      SSF_IDLE: begin
        if (toff_done_i) begin
          cr_d.st = SSF_RAMP;
          cr_d.ref_code = SSF_REF_W'((32'(boot_voltage_level_i) + 32'd1)
            * SSF_CODES_PER_LVL);
          cr_d.cnt = '0;
        end
      end
      SSF_RAMP: begin
        if (cr_q.ref_code == '0) begin
          cr_d.st = SSF_IDLE;
          cr_d.stop = 1'b1;
        end else if (cr_q.cnt >= tick_cyc - 16'h0001) begin
          cr_d.cnt = '0;
          cr_d.ref_code = cr_q.ref_code - 1'b1;
        end else begin
          cr_d.cnt = cr_q.cnt + 1'b1;
        end
        if (cr_q.cut_s2) begin
          cr_d.stop = 1'b1;
        end
      end
    endcase
    if (soft_start_i) begin
      cr_d.stop = 1'b0;
      cr_d.st = SSF_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cr_q <= cr_rst;
    end else begin
      cr_q <= cr_d;
    end
  end

  assign ref_code_o = cr_q.ref_code;
  assign ramp_active_o = cr_q.st == SSF_RAMP;
  assign sw_stop_o = cr_q.stop;
  assign fall_sel_o = fall_sel;
  assign summary_byte_o = cr_q.sb;
  assign ivd_set_o = cr_q.ivd;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence fall_bad_wr_s;
    req_new && lk_q.req.code == SSF_CMD_FALL && lk_q.req.wr && !fall_wr_ok;
  endsequence

  sequence ramp_start_s;
    cr_q.st == SSF_IDLE && toff_done_i && !soft_start_i;
  endsequence

  fall_read_a: assert property (
    req_new && lk_q.req.code == SSF_CMD_FALL && !lk_q.req.wr |=>
      cr_q.rsp.rdata[15:SSF_MANT_W] == SSF_FALL_FIXED && cr_q.rsp.ack)
    else $error("fall read exponent wrong");
  fall_wrok_a: assert property (
    req_new && lk_q.req.code == SSF_CMD_FALL && lk_q.req.wr && fall_wr_ok
      && !nvm_load_i |=> cr_q.mant == $past(lk_q.req.wdata[3:0]))
    else $error("mantissa not stored");
  fall_nack_a: assert property (
    fall_bad_wr_s and !nvm_load_i |=>
      !cr_q.rsp.ack && cr_q.ivd && $stable(cr_q.mant))
    else $error("read-only write not refused");
  sbyte_wr_a: assert property (
    req_new && lk_q.req.code == SSF_CMD_SBYTE && lk_q.req.wr |=>
      cr_q.ivd && !cr_q.rsp.ack)
    else $error("summary write not flagged");
  unsup_bits_a: assert property (
    !cr_q.sb[SSF_SB_NA7] && !cr_q.sb[SSF_SB_NA3])
    else $error("unsupported summary bit set");
  off_live_a: assert property (
    !secondary_i && !src_i.converting |=> cr_q.sb[SSF_SB_OFF])
    else $error("off bit not live");
  secondary_a: assert property (
    secondary_i |=> cr_q.sb == 8'h00)
    else $error("secondary summary not zero");
  ocur_src_a: assert property (
    !secondary_i && (src_i.output_overcurrent_fault ||
      src_i.overcurrent_undervoltage) |=> cr_q.sb[SSF_SB_OCUR])
    else $error("overcurrent summary missed");
  cut_stop_a: assert property (
    cr_q.st == SSF_RAMP && cr_q.cut_s2 && !soft_start_i |=> cr_q.stop)
    else $error("switching not stopped at cutoff");
  ramp_load_a: assert property (
    ramp_start_s |=> cr_q.st == SSF_RAMP && cr_q.ref_code != '0
      ##1 cr_q.ref_code <= $past(cr_q.ref_code) || soft_start_i)
    else $error("ramp did not start or rose");
endmodule

// File: ssf_host.sv
// Host model that issues command-link requests and collects answers.
`timescale 1ns/1ns
module ssf_host (
  // Link clock.
  input wire logic lk_clk_i,
  // Flow control and answers.
  input wire logic lk_req_ready_i,
  input wire logic lk_rsp_valid_i,
  input wire ssf_pkg::ssf_rsp_t lk_rsp_i,
  // Requests.
  output logic lk_req_valid_o,
  output ssf_pkg::ssf_req_t lk_req_o
);
  import ssf_pkg::*;
  initial begin
    lk_req_valid_o = 1'b0;
    lk_req_o = '0;
  end
  // Holds a request until taken, then scrambles the idle request lines.
  task automatic xfer(input ssf_req_t req, output ssf_rsp_t rsp,
    output logic got);
    int n;
    got = 1'b0;
    rsp = '0;
    @(posedge lk_clk_i);
    lk_req_valid_o <= 1'b1;
    lk_req_o <= req;
    n = 0;
    do begin
      @(posedge lk_clk_i);
      n++;
    end while (lk_req_ready_i !== 1'b1 && n < 40);
    lk_req_valid_o <= 1'b0;
    lk_req_o <= ~req;
    for (n = 0; n < 60 && !got; n++) begin
      @(posedge lk_clk_i);
      if (lk_rsp_valid_i === 1'b1) begin
        rsp = lk_rsp_i;
        got = 1'b1;
      end
    end
  endtask
endmodule

// File: ssf_regs_bench.sv
// Self-checking bench for the fall-time register and summary byte.
`timescale 1ns/1ns
module ssf_regs_bench;
  import ssf_pkg::*;
  localparam int FMIN = 1600;
  logic clk_i = 1'b0;
  logic lk_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic lk_rst_i = 1'b1;
  logic lk_req_valid_i, lk_req_ready_o, lk_rsp_valid_o;
  ssf_req_t lk_req_i;
  ssf_rsp_t lk_rsp_o;
  logic nvm_load_i = 1'b0;
  logic [1:0] nvm_sel_i = 2'h0;
  logic toff_done_i = 1'b0;
  logic soft_start_i = 1'b0;
  logic [4:0] boot_voltage_level_i = 5'h00;
  logic vout_cutoff_i = 1'b0;
  logic secondary_i = 1'b0;
  ssf_src_t src_i = 7'h40;
  logic [SSF_REF_W-1:0] ref_code_o;
  logic ramp_active_o, sw_stop_o, ivd_set_o;
  logic [1:0] fall_sel_o;
  logic [7:0] summary_byte_o;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int ivd_n = 0;
  initial forever #10 clk_i = ~clk_i;
  initial begin
    #2;
    forever #3 lk_clk_i = ~lk_clk_i;
  end
  ssf_regs #(.FALL_MIN_CYC(FMIN)) ssf_regs_inst (.clk_i, .rst_i, .lk_clk_i,
    .lk_rst_i, .lk_req_valid_i, .lk_req_i, .lk_req_ready_o, .lk_rsp_valid_o,
    .lk_rsp_o, .nvm_load_i, .nvm_sel_i, .toff_done_i, .soft_start_i,
    .boot_voltage_level_i, .vout_cutoff_i, .ref_code_o, .ramp_active_o,
    .sw_stop_o, .fall_sel_o, .src_i, .secondary_i, .summary_byte_o,
    .ivd_set_o);
  ssf_host ssf_host_inst (.lk_clk_i, .lk_req_ready_i(lk_req_ready_o),
    .lk_rsp_valid_i(lk_rsp_valid_o), .lk_rsp_i(lk_rsp_o),
    .lk_req_valid_o(lk_req_valid_i), .lk_req_o(lk_req_i));
  task automatic report_and_stop();
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp, input int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fails++;
      $display("BAD %0t took %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic xact(input logic [7:0] c, input logic w,
    input logic [15:0] d, input logic a, input logic [15:0] e);
    ssf_rsp_t r;
    logic g;
    ssf_host_inst.xfer('{code: c, wr: w, wdata: d}, r, g);
    chk({15'h0, g}, 16'h1);
    chk({15'h0, r.ack}, {15'h0, a});
    if (a) begin
      chk(r.rdata, e);
    end
  endtask
  function automatic logic [1:0] fs(input logic [3:0] v);
    fs = v < 4'h2 ? 2'h0 : v < 4'h4 ? 2'h1 : v < 4'h8 ? 2'h2 : 2'h3;
  endfunction
  function automatic logic [7:0] sb(input ssf_src_t s, input logic sec);
    sb = sec ? 8'h00 : {1'b0, ~s.converting, s.output_overvoltage_fault,
      s.output_overcurrent_fault | s.overcurrent_undervoltage, 1'b0,
      s.temperature_fault_warning, s.cml_fault, s.other_fault};
  endfunction
  task automatic ramp(input logic [4:0] lv, input logic [3:0] mt,
    input logic cut);
    int codes, step, n;
    codes = (lv + 1) * 16;
    step = (FMIN / codes) << fs(mt);
    xact(SSF_CMD_FALL, 1'b1, {12'hf80, mt}, 1'b1, 16'h0);
    @(posedge clk_i);
    boot_voltage_level_i <= lv;
    soft_start_i <= 1'b1;
    @(posedge clk_i);
    soft_start_i <= 1'b0;
    toff_done_i <= 1'b1;
    @(posedge clk_i);
    toff_done_i <= 1'b0;
    @(negedge clk_i);
    chk({15'h0, ramp_active_o}, 16'h1);
    chk(16'(ref_code_o), 16'(codes));
    if (cut) begin
      @(posedge clk_i);
      vout_cutoff_i <= 1'b1;
      repeat (5) @(negedge clk_i);
      chk({15'h0, sw_stop_o}, 16'h1);
      @(posedge clk_i);
      vout_cutoff_i <= 1'b0;
    end else begin
      n = 0;
      while (ramp_active_o === 1'b1 && n < 9000) begin
        @(negedge clk_i);
        n++;
      end
      near(n, codes * step, step + 3);
      chk({5'h0, sw_stop_o, ref_code_o}, 16'h0400);
    end
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      report_and_stop();
    end
  end
  always @(posedge clk_i) begin
    if (ivd_set_o === 1'b1) begin
      ivd_n++;
    end
  end
  initial begin
    int m, n0;
    logic [7:0] e, s;
    logic [3:0] nv [4];
    nv = '{4'h0, 4'h2, 4'h4, 4'h8};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    lk_rst_i <= 1'b0;
    @(negedge clk_i);
    chk({8'h00, summary_byte_o}, 16'h0040);
    xact(SSF_CMD_FALL, 1'b0, 16'h0, 1'b1, 16'hf800);
    xact(SSF_CMD_SBYTE, 1'b0, 16'h0, 1'b1, 16'h0000);
    for (m = 0; m < 16; m++) begin
      xact(SSF_CMD_FALL, 1'b1, {12'hf80, 4'(m)}, 1'b1, 16'h0);
      xact(SSF_CMD_FALL, 1'b0, 16'h0, 1'b1, {12'hf80, 4'(m)});
      chk({14'h0, fall_sel_o}, {14'h0, fs(4'(m))});
    end
    n0 = ivd_n;
    xact(SSF_CMD_FALL, 1'b1, 16'hf815, 1'b0, 16'h0);
    xact(SSF_CMD_FALL, 1'b1, 16'h7805, 1'b0, 16'h0);
    xact(SSF_CMD_SBYTE, 1'b1, 16'h0000, 1'b0, 16'h0);
    xact(SSF_CMD_FALL, 1'b0, 16'h0, 1'b1, 16'hf80f);
    chk(16'(ivd_n - n0), 16'h3);
    for (m = 0; m < 4; m++) begin
      @(posedge clk_i);
      nvm_sel_i <= 2'(m);
      nvm_load_i <= 1'b1;
      @(posedge clk_i);
      nvm_load_i <= 1'b0;
      xact(SSF_CMD_FALL, 1'b0, 16'h0, 1'b1, {12'hf80, nv[m]});
    end
    for (m = 0; m < 256; m++) begin
      @(posedge clk_i);
      src_i <= m[6:0];
      secondary_i <= m[7];
      repeat (2) @(negedge clk_i);
      s = summary_byte_o;
      e = sb(m[6:0], m[7]);
      chk({13'h0, s[6:4]}, {13'h0, e[6:4]});
      chk({13'h0, s[2:0]}, {13'h0, e[2:0]});
      chk({14'h0, s[7], s[3]}, 16'h0);
    end
    @(posedge clk_i);
    src_i <= 7'h55;
    secondary_i <= 1'b0;
    xact(SSF_CMD_SBYTE, 1'b0, 16'h0, 1'b1,
      {8'h00, sb(7'h55, 1'b0)});
    ramp(5'd0, 4'h0, 1'b0);
    ramp(5'd31, 4'h2, 1'b0);
    ramp(5'd15, 4'h4, 1'b0);
    ramp(5'd0, 4'h0, 1'b1);
    report_and_stop();
  end
endmodule
